/* logic/cpu_regs_defs.svh */
// constants for the core register set and operand addressing
// assumes one 100 MHz clock and a data port with one cycle read latency
`ifndef CPU_REGS_DEFS_SVH
`define CPU_REGS_DEFS_SVH
`define F_GIE_BIT 0
`define F_ZERO_BIT 1
`define F_CARRY_BIT 2
`define F_SUPER_BIT 3
`define F_BANK_BIT 4
`define F_RESET 8'h02
`define F_WRITE_MASK 8'h17
`define F_SUPER_MASK 8'h08
`define F_REG_ADDR 8'hF7
`define BYTE_RESET 8'h00
`define PC_RESET 16'h0000
`define PC_STEP 16'h0002
`define BYTE_ZERO 8'h00
`endif

/* logic/cpu_regs_pkg.sv */
// types shared by the core register set and its operation unit
// assumes the constants header is included by the design files
package cpu_regs_pkg;
    typedef enum logic [1:0] {MODE_SRC_IMM, MODE_SRC_DIR, MODE_SRC_IDX, MODE_DST_DIR} mode_e;
    typedef enum logic [1:0] {TGT_A, TGT_X, TGT_F, TGT_SP} target_e;
    typedef enum logic {SPACE_RAM, SPACE_REG} space_e;
    typedef enum logic [2:0] {
        OP_MOV, OP_ADD, OP_ADC, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_CMP
    } alu_op_e;
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_EXEC} state_e;
    typedef struct packed {
        mode_e mode;
        target_e target;
        space_e space;
        alu_op_e op;
        logic [7:0] operand;
    } instr_s;
    typedef struct packed {
        logic req;
        logic we;
        space_e space;
        logic bank;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mem_req_s;
    typedef struct packed {
        logic [7:0] result;
        logic carry;
        logic zero;
        logic upd_c;
        logic upd_z;
        logic write;
    } alu_res_s;
    typedef struct packed {
        state_e state;
        instr_s ins;
        logic use_flags;
        logic [7:0] addr;
        logic [7:0] acc;
        logic [7:0] idx;
        logic [7:0] sp;
        logic [7:0] pch;
        logic [7:0] pcl;
        logic [7:0] flags;
        mem_req_s mem;
        logic done;
        logic busy;
        logic irq_taken;
    } core_s;
endpackage : cpu_regs_pkg

/* logic/cpu_alu.sv */
// operation unit: one combinational step of the arithmetic and logic ops
// assumes operands and carry in are held stable by the core
`timescale 1ns/1ps
`include "cpu_regs_defs.svh"
module cpu_alu (
    input wire cpu_regs_pkg::alu_op_e op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic carry_in,
    output cpu_regs_pkg::alu_res_s res
);
    import cpu_regs_pkg::*;
    logic [8:0] wide;
    always_comb begin
        wide = {1'b0, b};
        res = '0;
        res.upd_c = 1'b1;
        res.upd_z = 1'b1;
        res.write = 1'b1;
        case (op)
            OP_MOV: begin
                res.upd_c = 1'b0;
                res.upd_z = 1'b0;
            end
            OP_ADD: wide = {1'b0, a} + {1'b0, b};
            OP_ADC: wide = {1'b0, a} + {1'b0, b} + {8'h00, carry_in};
            OP_SUB: wide = {1'b0, a} - {1'b0, b};
            OP_AND: wide = {1'b0, a & b};
            OP_OR: wide = {1'b0, a | b};
            OP_XOR: wide = {1'b0, a ^ b};
            OP_CMP: begin
                wide = {1'b0, a} - {1'b0, b};
                res.write = 1'b0;
            end
            default: res.write = 1'b0;
        endcase
        res.result = wide[7:0];
        res.carry = wide[8];
        res.zero = (wide[7:0] == `BYTE_ZERO);
    end
endmodule : cpu_alu

/* logic/cpu_regs_core.sv */
// core register set with source immediate, direct, indexed and destination direct modes
// assumes a decoded instruction strobe and a data port that answers reads one cycle later
`timescale 1ns/1ps
`include "cpu_regs_defs.svh"
module cpu_regs_core (
    input wire logic clock,
    input wire logic nrst,
    input wire logic instr_valid,
    input wire cpu_regs_pkg::instr_s instr,
    input wire logic pc_load,
    input wire logic [15:0] pc_value,
    input wire logic sp_adjust,
    input wire logic [7:0] sp_delta,
    input wire logic super_enter,
    input wire logic super_exit,
    input wire logic irq_pending,
    input wire logic [7:0] mem_rdata,
    output cpu_regs_pkg::mem_req_s mem,
    output logic [7:0] accumulator,
    output logic [7:0] index_register,
    output logic [7:0] stack_pointer,
    output logic [7:0] program_counter_high,
    output logic [7:0] program_counter_low,
    output logic [7:0] cpu_flags,
    output logic busy,
    output logic done,
    output logic irq_taken
);
    import cpu_regs_pkg::*;

    logic [1:0] rst_sync_q;
    logic rst_n;
    core_s s_q;
    core_s s_d;
    logic [7:0] alu_a;
    logic [7:0] alu_b;
    logic [7:0] src_val;
    logic [7:0] tgt_val;
    logic [7:0] idle_addr;
    logic [15:0] pc_cur;
    logic [15:0] pc_next;
    alu_res_s alu_res;

    // reset release through two flops
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // register selected by the target field
    function automatic logic [7:0] pick_target(input target_e t, input core_s s);
        logic [7:0] v;
        v = s.acc;
        case (t)
            TGT_A: v = s.acc;
            TGT_X: v = s.idx;
            TGT_F: v = s.flags;
            TGT_SP: v = s.sp;
            default: v = s.acc;
        endcase
        return v;
    endfunction : pick_target

    // true when the access names the flags word in register space
    function automatic logic is_flags_addr(input space_e sp, input logic [7:0] a);
        return (sp == SPACE_REG) && (a == `F_REG_ADDR);
    endfunction : is_flags_addr

    assign pc_cur = {s_q.pch, s_q.pcl};

    // operand selection for the operation unit
    always_comb begin
        idle_addr = instr.operand;
        if (instr.mode == MODE_SRC_IDX) begin
            idle_addr = instr.operand + s_q.idx;
        end
        tgt_val = pick_target(s_q.ins.target, s_q);
        if (s_q.ins.mode == MODE_SRC_IMM) begin
            src_val = s_q.ins.operand;
        end else if (s_q.use_flags) begin
            src_val = s_q.flags;
        end else begin
            src_val = mem_rdata;
        end
        if (s_q.ins.mode == MODE_DST_DIR) begin
            alu_a = src_val;
            alu_b = tgt_val;
        end else begin
            alu_a = tgt_val;
            alu_b = src_val;
        end
    end

    cpu_alu alu_i (
        .op(s_q.ins.op),
        .a(alu_a),
        .b(alu_b),
        .carry_in(s_q.flags[`F_CARRY_BIT]),
        .res(alu_res)
    );

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.mem.req = 1'b0;
        s_d.mem.we = 1'b0;
        s_d.irq_taken = irq_pending & s_q.flags[`F_GIE_BIT];
        pc_next = pc_cur;
        if (sp_adjust) begin
            s_d.sp = s_q.sp + sp_delta;
        end
        case (s_q.state)
            ST_IDLE: begin
                if (instr_valid) begin
                    s_d.ins = instr;
                    s_d.addr = idle_addr;
                    s_d.use_flags = 1'b0;
                    pc_next = pc_cur + `PC_STEP;
                    if (instr.mode == MODE_SRC_IMM) begin
                        s_d.state = ST_EXEC;
                    end else if (is_flags_addr(instr.space, idle_addr)) begin
                        s_d.use_flags = 1'b1;
                        s_d.state = ST_EXEC;
                    end else begin
                        s_d.mem.req = 1'b1;
                        s_d.mem.space = instr.space;
                        s_d.mem.bank = s_q.flags[`F_BANK_BIT];
                        s_d.mem.addr = idle_addr;
                        s_d.state = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                s_d.state = ST_EXEC;
            end
            ST_EXEC: begin
                s_d.state = ST_IDLE;
                s_d.done = 1'b1;
                if (s_q.ins.mode == MODE_DST_DIR) begin
                    if (alu_res.write && !is_flags_addr(s_q.ins.space, s_q.addr)) begin
                        s_d.mem.req = 1'b1;
                        s_d.mem.we = 1'b1;
                        s_d.mem.space = s_q.ins.space;
                        s_d.mem.bank = s_q.flags[`F_BANK_BIT];
                        s_d.mem.addr = s_q.addr;
                        s_d.mem.wdata = alu_res.result;
                    end
                end else if (s_q.ins.target == TGT_F) begin
                    if (s_q.ins.op == OP_AND || s_q.ins.op == OP_OR) begin
                        s_d.flags = (alu_res.result & `F_WRITE_MASK)
                                    | (s_q.flags & `F_SUPER_MASK);
                    end
                end else if (alu_res.write) begin
                    case (s_q.ins.target)
                        TGT_A: s_d.acc = alu_res.result;
                        TGT_X: s_d.idx = alu_res.result;
                        TGT_SP: s_d.sp = alu_res.result;
                        default: s_d.acc = s_q.acc;
                    endcase
                end
                if (s_q.ins.target != TGT_F || s_q.ins.mode == MODE_DST_DIR) begin
                    if (alu_res.upd_c) begin
                        s_d.flags[`F_CARRY_BIT] = alu_res.carry;
                    end
                    if (alu_res.upd_z) begin
                        s_d.flags[`F_ZERO_BIT] = alu_res.zero;
                    end
                end
            end
            default: begin
                s_d.state = ST_IDLE;
            end
        endcase
        if (pc_load) begin
            pc_next = pc_value;
        end
        s_d.pch = pc_next[15:8];
        s_d.pcl = pc_next[7:0];
        if (super_enter) begin
            s_d.flags[`F_SUPER_BIT] = 1'b1;
        end else if (super_exit) begin
            s_d.flags[`F_SUPER_BIT] = 1'b0;
        end
        s_d.busy = (s_d.state != ST_IDLE);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.state <= ST_IDLE;
            s_q.acc <= `BYTE_RESET;
            s_q.idx <= `BYTE_RESET;
            s_q.sp <= `BYTE_RESET;
            s_q.pch <= 8'(`PC_RESET >> 8);
            s_q.pcl <= `BYTE_RESET;
            s_q.flags <= `F_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign mem = s_q.mem;
    assign accumulator = s_q.acc;
    assign index_register = s_q.idx;
    assign stack_pointer = s_q.sp;
    assign program_counter_high = s_q.pch;
    assign program_counter_low = s_q.pcl;
    assign cpu_flags = s_q.flags;
    assign busy = s_q.busy;
    assign done = s_q.done;
    assign irq_taken = s_q.irq_taken;
endmodule : cpu_regs_core

/* sim/cpu_regs_core_sva.sv */
// assertions on the core register set ports
// assumes a bind onto cpu_regs_core and one clock domain
`timescale 1ns/1ps
`include "cpu_regs_defs.svh"
module cpu_regs_core_sva (
    input wire logic clock,
    input wire logic nrst,
    input wire logic pc_load,
    input wire logic sp_adjust,
    input wire logic [7:0] sp_delta,
    input wire logic super_enter,
    input wire logic super_exit,
    input wire logic irq_pending,
    input wire cpu_regs_pkg::mem_req_s mem,
    input wire logic [7:0] accumulator,
    input wire logic [7:0] index_register,
    input wire logic [7:0] stack_pointer,
    input wire logic [7:0] program_counter_high,
    input wire logic [7:0] program_counter_low,
    input wire logic [7:0] cpu_flags,
    input wire logic busy,
    input wire logic done,
    input wire logic irq_taken
);
    import cpu_regs_pkg::*;
    logic [1:0] up_q;
    wire logic up;
    wire logic [15:0] pc;
    assign up = (up_q == 2'h3);
    assign pc = {program_counter_high, program_counter_low};
    // counts edges until the internal reset copy has let go
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            up_q <= 2'h0;
        end else if (!up) begin
            up_q <= up_q + 2'h1;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    a_flags_reserved: assert property (cpu_flags[7:5] == 3'h0)
        else $error("reserved flags set");
    a_super_set: assert property (up && super_enter |=> cpu_flags[3])
        else $error("super not set");
    a_super_hold: assert property (up && !super_enter && !super_exit |=> $stable(cpu_flags[3]))
        else $error("super changed");
    a_irq_gate: assert property (up |=> irq_taken == ($past(irq_pending) && $past(cpu_flags[0])))
        else $error("irq gate wrong");
    a_read_done: assert property (mem.req && !mem.we |-> ##2 done)
        else $error("read not done");
    a_write_done: assert property (mem.req && mem.we |-> done && $stable(accumulator))
        else $error("write not clean");
    a_bank_follow: assert property (mem.req |-> mem.bank == cpu_flags[4])
        else $error("bank wrong");
    a_no_flags_bus: assert property (mem.req && mem.space == SPACE_REG |-> mem.addr != `F_REG_ADDR)
        else $error("flags on bus");
    a_pc_step: assert property ($rose(busy) && !$past(pc_load) |-> pc == $past(pc) + 16'h0002)
        else $error("pc step wrong");
    a_sp_adjust: assert property (up && sp_adjust && !busy |=>
        stack_pointer == $past(stack_pointer) + $past(sp_delta)) else $error("sp adjust wrong");
    c_write: cover property (mem.req && mem.we);
    c_read: cover property (mem.req && !mem.we);
    c_irq: cover property (irq_taken);
endmodule : cpu_regs_core_sva
bind cpu_regs_core cpu_regs_core_sva u_sva (.clock, .nrst, .pc_load, .sp_adjust, .sp_delta,
    .super_enter, .super_exit, .irq_pending, .mem, .accumulator, .index_register, .stack_pointer,
    .program_counter_high, .program_counter_low, .cpu_flags, .busy, .done, .irq_taken);

/* sim/data_space_model.sv */
// data RAM and two register banks behind the core's data port
// assumes reads are answered the cycle after the request
`timescale 1ns/1ps
module data_space_model (
    input wire logic clock,
    input wire cpu_regs_pkg::mem_req_s mem,
    output logic [7:0] mem_rdata
);
    import cpu_regs_pkg::*;
    logic [7:0] ram [256];
    logic [7:0] regs [512];
    initial begin
        mem_rdata = 8'h00;
        for (int i = 0; i < 512; i++) begin
            regs[i] = i[7:0] + (i[8] ? 8'h40 : 8'h80);
            ram[i[7:0]] = i[7:0] ^ 8'h5A;
        end
    end
    always @(posedge clock) begin
        if (mem.req && mem.we && mem.space == SPACE_RAM) ram[mem.addr] <= mem.wdata;
        if (mem.req && mem.we && mem.space == SPACE_REG) regs[{mem.bank, mem.addr}] <= mem.wdata;
        if (mem.req && !mem.we) begin
            mem_rdata <= (mem.space == SPACE_RAM) ? ram[mem.addr] : regs[{mem.bank, mem.addr}];
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule : data_space_model

/* sim/tb_top.sv */
// self-checking bench for the core register set
// assumes the data space model answers the data port
`timescale 1ns/1ps
module tb_top;
    import cpu_regs_pkg::*;
    typedef struct packed {
        instr_s i;
        logic [7:0] a, x, s, f, w;
    } row_s;
    logic clock, nrst, instr_valid, pc_load, sp_adjust, super_enter, super_exit, irq_pending;
    logic [15:0] pc_value;
    logic [7:0] sp_delta, mem_rdata, accumulator, index_register, stack_pointer, cpu_flags;
    logic [7:0] program_counter_high, program_counter_low;
    logic busy, done, irq_taken;
    instr_s instr;
    mem_req_s mem;
    int err_total, compares;
    int cyc = 0;
    row_s rows [13] = '{
        '{'{MODE_SRC_IMM, TGT_A, SPACE_RAM, OP_MOV, 8'h7F}, 8'h7F, 8'h00, 8'h00, 8'h02, 8'h00},
        '{'{MODE_SRC_IMM, TGT_A, SPACE_RAM, OP_ADD, 8'h81}, 8'h00, 8'h00, 8'h00, 8'h06, 8'h00},
        '{'{MODE_SRC_IMM, TGT_X, SPACE_RAM, OP_MOV, 8'h05}, 8'h00, 8'h05, 8'h00, 8'h06, 8'h00},
        '{'{MODE_SRC_DIR, TGT_A, SPACE_RAM, OP_ADC, 8'h10}, 8'h4B, 8'h05, 8'h00, 8'h00, 8'h00},
        '{'{MODE_SRC_IDX, TGT_X, SPACE_RAM, OP_ADD, 8'h03}, 8'h4B, 8'h57, 8'h00, 8'h00, 8'h00},
        '{'{MODE_SRC_DIR, TGT_A, SPACE_REG, OP_SUB, 8'h20}, 8'hAB, 8'h57, 8'h00, 8'h04, 8'h00},
        '{'{MODE_SRC_IMM, TGT_F, SPACE_RAM, OP_OR, 8'hF1}, 8'hAB, 8'h57, 8'h00, 8'h15, 8'h00},
        '{'{MODE_SRC_DIR, TGT_A, SPACE_REG, OP_XOR, 8'h20}, 8'hCB, 8'h57, 8'h00, 8'h11, 8'h00},
        '{'{MODE_SRC_IMM, TGT_F, SPACE_RAM, OP_AND, 8'hEE}, 8'hCB, 8'h57, 8'h00, 8'h00, 8'h00},
        '{'{MODE_SRC_IMM, TGT_SP, SPACE_RAM, OP_MOV, 8'h40}, 8'hCB, 8'h57, 8'h40, 8'h00, 8'h00},
        '{'{MODE_DST_DIR, TGT_A, SPACE_RAM, OP_ADD, 8'h30}, 8'hCB, 8'h57, 8'h40, 8'h04, 8'h35},
        '{'{MODE_SRC_DIR, TGT_X, SPACE_RAM, OP_MOV, 8'h30}, 8'hCB, 8'h35, 8'h40, 8'h04, 8'h00},
        '{'{MODE_SRC_IMM, TGT_A, SPACE_RAM, OP_CMP, 8'hCB}, 8'hCB, 8'h35, 8'h40, 8'h02, 8'h00}};
    cpu_regs_core u_dut (.clock, .nrst, .instr_valid, .instr, .pc_load, .pc_value, .sp_adjust,
        .sp_delta, .super_enter, .super_exit, .irq_pending, .mem_rdata, .mem, .accumulator,
        .index_register, .stack_pointer, .program_counter_high, .program_counter_low,
        .cpu_flags, .busy, .done, .irq_taken);
    data_space_model u_mem (.clock, .mem, .mem_rdata);
    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task run(input instr_s i);
        int n;
        n = 0;
        instr = i;
        instr_valid = 1'b1;
        @(negedge clock);
        instr_valid = 1'b0;
        chk(busy, 16'h0001);
        while (done !== 1'b1 && n < 8) begin
            @(negedge clock);
            n++;
        end
        chk(done, 16'h0001);
    endtask : run
    task do_reset;
        nrst = 1'b0;
        repeat (3) @(negedge clock);
        chk(accumulator, 8'h00);
        chk(index_register, 8'h00);
        chk(stack_pointer, 8'h00);
        chk({program_counter_high, program_counter_low}, 16'h0000);
        chk(cpu_flags, 8'h02);
        nrst = 1'b1;
        repeat (3) @(negedge clock);
        $display("reset test done");
    endtask : do_reset
    task summarize;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            summarize();
        end
    end
    initial begin
        {nrst, instr_valid, pc_load, sp_adjust, super_enter, super_exit, irq_pending} = '0;
        {instr, pc_value, sp_delta} = '0;
        {err_total, compares} = '0;
        @(negedge clock);
        do_reset();
        foreach (rows[k]) begin
            run(rows[k].i);
            chk(accumulator, rows[k].a);
            chk(index_register, rows[k].x);
            chk(stack_pointer, rows[k].s);
            chk(cpu_flags, rows[k].f);
            if (rows[k].i.mode == MODE_DST_DIR) chk(mem.wdata, rows[k].w);
        end
        chk({program_counter_high, program_counter_low}, 16'h001A);
        $display("row test done");
        run('{MODE_SRC_DIR, TGT_A, SPACE_REG, OP_MOV, 8'hF7});
        chk(accumulator, 8'h02);
        run('{MODE_DST_DIR, TGT_A, SPACE_REG, OP_MOV, 8'hF7});
        chk(mem.addr, 8'h30);
        chk(cpu_flags, 8'h02);
        super_enter = 1'b1;
        @(negedge clock);
        super_enter = 1'b0;
        run('{MODE_SRC_IMM, TGT_F, SPACE_RAM, OP_AND, 8'h00});
        chk(cpu_flags, 8'h08);
        super_exit = 1'b1;
        @(negedge clock);
        super_exit = 1'b0;
        chk(cpu_flags, 8'h00);
        irq_pending = 1'b1;
        repeat (2) @(negedge clock);
        chk(irq_taken, 1'b0);
        run('{MODE_SRC_IMM, TGT_F, SPACE_RAM, OP_OR, 8'h01});
        @(negedge clock);
        chk(irq_taken, 1'b1);
        irq_pending = 1'b0;
        sp_delta = 8'hFF;
        sp_adjust = 1'b1;
        @(negedge clock);
        sp_adjust = 1'b0;
        chk(stack_pointer, 8'h3F);
        pc_value = 16'h12FE;
        pc_load = 1'b1;
        @(negedge clock);
        pc_load = 1'b0;
        run('{MODE_SRC_IMM, TGT_A, SPACE_RAM, OP_MOV, 8'h00});
        chk({program_counter_high, program_counter_low}, 16'h1300);
        $display("edge test done");
        do_reset();
        summarize();
    end
endmodule : tb_top
